// ==== design/uspc_pin_cell.sv ====
`timescale 1ns/1ps
module uspc_pin_cell (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic nrst,
   // Requested drive
   input  wire logic drive,
   input  wire logic level,
   input  wire logic open_drain,
   // Pad side
   output logic      pin_out,
   output logic      pin_oe
);

   // Open-drain releases the pad for a high level
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pin_out <= 1'b0;
         pin_oe  <= 1'b0;
      end else begin
         pin_out <= open_drain ? 1'b0 : level;
         pin_oe  <= drive & (~open_drain | ~level);
      end
   end

endmodule

// ==== design/uspc_pkg.sv ====
package uspc_pkg;

   // Bus geometry
   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 32;
   localparam int NUM_PINS = 8;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_GPIO   = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_MODEM  = 8'h0C;

   // Config fields
   localparam int CFG_STD_MODEM_BIT = 0;
   localparam int CFG_ENH_MODEM_BIT = 1;
   localparam int CFG_POL_HIGH_BIT  = 2;
   localparam int CFG_SUSP_LVL_LSB  = 8;
   localparam int CFG_OD_LSB        = 16;

   // Runtime control fields
   localparam int GPIO_VAL_LSB      = 0;
   localparam int GPIO_DIR_LSB      = 8;
   localparam int MODEM_STD_DTR_BIT = 0;
   localparam int MODEM_ENH_DTR_BIT = 1;
   localparam int MODEM_STD_RTS_BIT = 2;
   localparam int MODEM_ENH_RTS_BIT = 3;

   // Status fields
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_IND_BIT   = 2;
   localparam int STAT_LOCK_BIT  = 3;
   localparam int STAT_CONF_BIT  = 4;
   localparam int STAT_PIN_LSB   = 8;
   localparam int STAT_MST_LSB   = 16;
   localparam int STAT_GRANT_LSB = 22;

   // Reset values
   localparam logic [DATA_W-1:0] CFG_RST   = 32'h0000_0000;
   localparam logic [DATA_W-1:0] GPIO_RST  = 32'h0000_0000;
   localparam logic [DATA_W-1:0] MODEM_RST = 32'h0000_0000;

   // Side pin indices
   localparam int PIN_ENH_USER0   = 0;
   localparam int PIN_ENH_USER1   = 1;
   localparam int PIN_ENH_CARRIER = 2;
   localparam int PIN_ENH_SUSPEND = 3;
   localparam int PIN_STD_USER0   = 4;
   localparam int PIN_STD_USER1   = 5;
   localparam int PIN_STD_USER2   = 6;
   localparam int PIN_STD_SUSPEND = 7;

   // Pin roles
   localparam logic [NUM_PINS-1:0] PIN_ENH_MASK  = 8'h0F;
   localparam logic [NUM_PINS-1:0] PIN_GPIO_MASK = 8'h73;
   localparam logic [NUM_PINS-1:0] PIN_SUS_MASK  = 8'h88;
   localparam logic [NUM_PINS-1:0] PIN_MOUT_MASK = 8'h21;

   // Modem status layout per port
   localparam int MST_DSR = 0;
   localparam int MST_DCD = 1;
   localparam int MST_RI  = 2;

   typedef enum logic [1:0] {
      UST_UNCONF = 2'b00,
      UST_ACTIVE = 2'b01,
      UST_SUSP   = 2'b11
   } uspc_state_t;

endpackage

// ==== design/uspc_sync.sv ====
`timescale 1ns/1ps
module uspc_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '1
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             nrst,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   // Two-stage synchroniser
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

// ==== design/uspc_top.sv ====
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module uspc_top (
   // Clock and reset
   input  wire logic                         clk_sys,
   input  wire logic                         nrst,
   // USB core events
   input  wire logic                         usb_suspend_det,
   input  wire logic                         usb_resume_det,
   input  wire logic                         usb_resume_gen,
   input  wire logic                         usb_bus_reset,
   input  wire logic                         usb_config_done,
   // Register port
   input  wire logic [uspc_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [uspc_pkg::DATA_W-1:0]  reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output logic      [uspc_pkg::DATA_W-1:0]  reg_rdata,
   // Flow control pins
   input  wire logic                         std_clear_to_send_n,
   input  wire logic                         enh_clear_to_send_n,
   output logic                              std_ready_to_send_n,
   output logic                              enh_ready_to_send_n,
   // UART core side
   input  wire logic                         std_rx_ready,
   input  wire logic                         enh_rx_ready,
   output logic                              std_tx_grant,
   output logic                              enh_tx_grant,
   output logic      [2:0]                   std_modem_status,
   output logic      [2:0]                   enh_modem_status,
   output logic                              enh_modem_mode,
   output logic                              std_modem_mode,
   // Side pins
   input  wire logic [uspc_pkg::NUM_PINS-1:0] side_pin_in,
   output logic      [uspc_pkg::NUM_PINS-1:0] side_pin_out,
   output logic      [uspc_pkg::NUM_PINS-1:0] side_pin_oe
);

   localparam int NP = uspc_pkg::NUM_PINS;

   uspc_pkg::uspc_state_t state_reg;
   uspc_pkg::uspc_state_t state_next;

   logic [uspc_pkg::DATA_W-1:0] cfg_reg;
   logic [uspc_pkg::DATA_W-1:0] gpio_reg;
   logic [uspc_pkg::DATA_W-1:0] modem_reg;
   logic                        cfg_lock_reg;
   logic                        configured_reg;
   logic [NP+1:0]               sync_q;
   logic [NP-1:0]               pin_sync;
   logic                        std_cts_sync_n;
   logic                        enh_cts_sync_n;
   logic                        wr_cfg;
   logic                        wr_gpio;
   logic                        wr_modem;
   logic                        mode_std;
   logic                        mode_enh;
   logic                        pol_high;
   logic [NP-1:0]               susp_lvl;
   logic [NP-1:0]               gpio_od;
   logic [NP-1:0]               gpio_val;
   logic [NP-1:0]               gpio_dir;
   logic                        suspended;
   logic                        susp_assert;
   logic                        sus_level;
   logic                        any_exit;
   logic [NP-1:0]               pin_drive;
   logic [NP-1:0]               pin_level;
   logic [NP-1:0]               pin_od;
   logic [uspc_pkg::DATA_W-1:0] status_word;
   logic [uspc_pkg::DATA_W-1:0] rd_next;

   // Config and GPIO field views
   assign mode_std = cfg_reg[uspc_pkg::CFG_STD_MODEM_BIT];
   assign mode_enh = cfg_reg[uspc_pkg::CFG_ENH_MODEM_BIT];
   assign pol_high = cfg_reg[uspc_pkg::CFG_POL_HIGH_BIT];
   assign susp_lvl = cfg_reg[uspc_pkg::CFG_SUSP_LVL_LSB +: NP];
   assign gpio_od  = cfg_reg[uspc_pkg::CFG_OD_LSB +: NP];
   assign gpio_val = gpio_reg[uspc_pkg::GPIO_VAL_LSB +: NP];
   assign gpio_dir = gpio_reg[uspc_pkg::GPIO_DIR_LSB +: NP];
   assign std_modem_mode = mode_std;
   assign enh_modem_mode = mode_enh;

   // Input synchronisers
   uspc_sync #(
      .WIDTH   (NP + 2),
      .RST_VAL ({(NP + 2){1'b1}})
   ) u_sync (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .async_in ({enh_clear_to_send_n, std_clear_to_send_n, side_pin_in}),
      .sync_out (sync_q)
   );

   assign pin_sync       = sync_q[NP-1:0];
   assign std_cts_sync_n = sync_q[NP];
   assign enh_cts_sync_n = sync_q[NP+1];

   // Suspend state machine
   assign any_exit = usb_resume_det | usb_resume_gen | usb_bus_reset;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         uspc_pkg::UST_UNCONF: begin
            if (usb_suspend_det) begin
               state_next = uspc_pkg::UST_SUSP;
            end else if (usb_config_done) begin
               state_next = uspc_pkg::UST_ACTIVE;
            end
         end
         uspc_pkg::UST_ACTIVE: begin
            if (usb_suspend_det) begin
               state_next = uspc_pkg::UST_SUSP;
            end
         end
         uspc_pkg::UST_SUSP: begin
            if (any_exit) begin
               state_next = configured_reg ? uspc_pkg::UST_ACTIVE
                                           : uspc_pkg::UST_UNCONF;
            end
         end
         default: begin
            state_next = uspc_pkg::UST_UNCONF;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_reg <= uspc_pkg::UST_UNCONF;
      end else begin
         state_reg <= state_next;
      end
   end

   // Enumeration done flag
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         configured_reg <= 1'b0;
      end else if (usb_config_done) begin
         configured_reg <= 1'b1;
      end
   end

   // Indicator level
   assign suspended   = (state_reg == uspc_pkg::UST_SUSP);
   assign susp_assert = (state_reg != uspc_pkg::UST_ACTIVE);
   assign sus_level   = pol_high ? susp_assert : ~susp_assert;

   // Register write decode
   assign wr_cfg   = reg_wr && (reg_addr == uspc_pkg::OFS_CONFIG);
   assign wr_gpio  = reg_wr && (reg_addr == uspc_pkg::OFS_GPIO);
   assign wr_modem = reg_wr && (reg_addr == uspc_pkg::OFS_MODEM);

   // Write-once config store
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cfg_reg      <= uspc_pkg::CFG_RST;
         cfg_lock_reg <= 1'b0;
      end else if (wr_cfg && !cfg_lock_reg) begin
         cfg_reg      <= reg_wdata;
         cfg_lock_reg <= 1'b1;
      end
   end

   // Runtime GPIO control
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         gpio_reg <= uspc_pkg::GPIO_RST;
      end else if (wr_gpio) begin
         gpio_reg <= reg_wdata;
      end
   end

   // Runtime modem control
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         modem_reg <= uspc_pkg::MODEM_RST;
      end else if (wr_modem) begin
         modem_reg <= reg_wdata;
      end
   end

   // Per-pin function mux
   genvar gi;
   generate
      for (gi = 0; gi < NP; gi++) begin : g_pin
         logic port_modem;
         logic port_dtr;
         assign port_modem = uspc_pkg::PIN_ENH_MASK[gi] ? mode_enh : mode_std;
         assign port_dtr   = uspc_pkg::PIN_ENH_MASK[gi]
                             ? modem_reg[uspc_pkg::MODEM_ENH_DTR_BIT]
                             : modem_reg[uspc_pkg::MODEM_STD_DTR_BIT];
         assign pin_drive[gi] = port_modem ? uspc_pkg::PIN_MOUT_MASK[gi]
                              : (uspc_pkg::PIN_SUS_MASK[gi]
                                 | (uspc_pkg::PIN_GPIO_MASK[gi] & gpio_dir[gi]));
         assign pin_level[gi] = port_modem ? ~port_dtr
                              : uspc_pkg::PIN_SUS_MASK[gi] ? sus_level
                              : suspended ? susp_lvl[gi] : gpio_val[gi];
         assign pin_od[gi]    = ~port_modem & uspc_pkg::PIN_GPIO_MASK[gi] & gpio_od[gi];
         uspc_pin_cell u_cell (
            .clk_sys    (clk_sys),
            .nrst       (nrst),
            .drive      (pin_drive[gi]),
            .level      (pin_level[gi]),
            .open_drain (pin_od[gi]),
            .pin_out    (side_pin_out[gi]),
            .pin_oe     (side_pin_oe[gi])
         );
      end
   endgenerate

   // Modem inputs, active low at the pin
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         std_modem_status <= 3'h0;
         enh_modem_status <= 3'h0;
      end else begin
         enh_modem_status[uspc_pkg::MST_DSR] <=
            mode_enh & ~pin_sync[uspc_pkg::PIN_ENH_USER1];
         enh_modem_status[uspc_pkg::MST_DCD] <=
            mode_enh & ~pin_sync[uspc_pkg::PIN_ENH_CARRIER];
         enh_modem_status[uspc_pkg::MST_RI]  <=
            mode_enh & ~pin_sync[uspc_pkg::PIN_ENH_SUSPEND];
         std_modem_status[uspc_pkg::MST_DCD] <=
            mode_std & ~pin_sync[uspc_pkg::PIN_STD_USER0];
         std_modem_status[uspc_pkg::MST_DSR] <=
            mode_std & ~pin_sync[uspc_pkg::PIN_STD_USER2];
         std_modem_status[uspc_pkg::MST_RI]  <=
            mode_std & ~pin_sync[uspc_pkg::PIN_STD_SUSPEND];
      end
   end

   // Flow control
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         std_tx_grant        <= 1'b0;
         enh_tx_grant        <= 1'b0;
         std_ready_to_send_n <= 1'b1;
         enh_ready_to_send_n <= 1'b1;
      end else begin
         std_tx_grant        <= ~std_cts_sync_n;
         enh_tx_grant        <= ~enh_cts_sync_n;
         std_ready_to_send_n <= ~(std_rx_ready | modem_reg[uspc_pkg::MODEM_STD_RTS_BIT]);
         enh_ready_to_send_n <= ~(enh_rx_ready | modem_reg[uspc_pkg::MODEM_ENH_RTS_BIT]);
      end
   end

   // Status word
   always_comb begin
      status_word = '0;
      status_word[uspc_pkg::STAT_STATE_LSB +: 2] = state_reg;
      status_word[uspc_pkg::STAT_IND_BIT]        = susp_assert;
      status_word[uspc_pkg::STAT_LOCK_BIT]       = cfg_lock_reg;
      status_word[uspc_pkg::STAT_CONF_BIT]       = configured_reg;
      status_word[uspc_pkg::STAT_PIN_LSB +: NP]  = pin_sync;
      status_word[uspc_pkg::STAT_MST_LSB +: 6]   = {enh_modem_status, std_modem_status};
      status_word[uspc_pkg::STAT_GRANT_LSB +: 2] = {enh_tx_grant, std_tx_grant};
   end

   // Read mux, unmapped reads zero
   always_comb begin
      rd_next = '0;
      unique case (reg_addr)
         uspc_pkg::OFS_STATUS: rd_next = status_word;
         uspc_pkg::OFS_CONFIG: rd_next = cfg_reg;
         uspc_pkg::OFS_GPIO:   rd_next = gpio_reg;
         uspc_pkg::OFS_MODEM:  rd_next = modem_reg;
         default:              rd_next = '0;
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_rd ? rd_next : '0;
      end
   end

   // Checks
   susp_entry_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      usb_suspend_det && (state_reg != uspc_pkg::UST_SUSP)
      |=> state_reg == uspc_pkg::UST_SUSP)
      else $error("suspend not entered");

   susp_gpio_pin_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (state_reg == uspc_pkg::UST_SUSP) && cfg_lock_reg && !mode_enh
      |=> side_pin_oe[uspc_pkg::PIN_ENH_SUSPEND]
          && (side_pin_out[uspc_pkg::PIN_ENH_SUSPEND] == pol_high))
      else $error("suspend pin not asserted");

   unconf_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      !configured_reg && !usb_config_done |=> state_reg != uspc_pkg::UST_ACTIVE)
      else $error("indicator released before configuration");

   low_polarity_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      cfg_lock_reg && !pol_high && !mode_std && susp_assert
      |=> !side_pin_out[uspc_pkg::PIN_STD_SUSPEND])
      else $error("active-low indicator wrong");

   susp_exit_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (state_reg == uspc_pkg::UST_SUSP) && any_exit
      |=> state_reg != uspc_pkg::UST_SUSP)
      else $error("suspend not left");

   exit_deassert_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (state_reg == uspc_pkg::UST_SUSP) ##1 (state_reg == uspc_pkg::UST_ACTIVE)
      && cfg_lock_reg && !mode_enh
      |=> side_pin_out[uspc_pkg::PIN_ENH_SUSPEND] == !pol_high)
      else $error("indicator not deasserted");

   susp_level_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      suspended && !mode_enh && gpio_dir[uspc_pkg::PIN_ENH_USER0]
      && !gpio_od[uspc_pkg::PIN_ENH_USER0]
      |=> side_pin_oe[uspc_pkg::PIN_ENH_USER0]
          && (side_pin_out[uspc_pkg::PIN_ENH_USER0]
              == $past(susp_lvl[uspc_pkg::PIN_ENH_USER0])))
      else $error("suspend level wrong");

   cts_grant_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (!enh_clear_to_send_n) [*3] |=> enh_tx_grant)
      else $error("clear-to-send low not granted");

   cts_block_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      std_clear_to_send_n [*3] |=> !std_tx_grant)
      else $error("clear-to-send high granted");

   rts_low_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      enh_rx_ready |=> !enh_ready_to_send_n)
      else $error("ready-to-send not low");

   dtr_drive_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      cfg_lock_reg && mode_enh && modem_reg[uspc_pkg::MODEM_ENH_DTR_BIT]
      |=> side_pin_oe[uspc_pkg::PIN_ENH_USER0] && !side_pin_out[uspc_pkg::PIN_ENH_USER0])
      else $error("terminal-ready not driven low");

   dsr_sample_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (cfg_lock_reg && mode_enh && !side_pin_in[uspc_pkg::PIN_ENH_USER1]) [*4]
      |=> enh_modem_status[uspc_pkg::MST_DSR])
      else $error("set-ready not seen");

   cfg_once_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      cfg_lock_reg |=> $stable(cfg_reg) && cfg_lock_reg)
      else $error("config changed after lock");

endmodule

// ==== verification/usb_suspend_pin_control_bench.sv ====
`timescale 1ns/1ps
module usb_suspend_pin_control_bench;
   typedef struct packed {
      logic [1:0]  kind;
      logic [31:0] mask;
      logic [31:0] exp;
   } uspc_note_t;

   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   logic [4:0]  ev = 5'h00;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic        std_clear_to_send_n = 1'b1;
   logic        enh_clear_to_send_n = 1'b1;
   logic        std_rx_ready = 1'b0;
   logic        enh_rx_ready = 1'b0;
   logic        std_ready_to_send_n, enh_ready_to_send_n, std_tx_grant, enh_tx_grant;
   logic        std_modem_mode, enh_modem_mode;
   logic [2:0]  std_modem_status, enh_modem_status;
   logic [7:0]  pad, pin_out, pin_oe;
   logic [7:0]  ext_en = 8'h00;
   logic [7:0]  ext_lvl = 8'h00;
   logic [31:0] misc, lfsr;
   logic [7:0]  gv, gd;
   logic        rd_d = 1'b0;
   logic        obs_req = 1'b0;
   int          fail_count = 0;
   int          n_checks = 0;
   uspc_note_t  notes[$];

   assign misc = {20'h0, std_tx_grant, enh_tx_grant, std_ready_to_send_n, enh_ready_to_send_n,
                  std_modem_mode, enh_modem_mode, std_modem_status, enh_modem_status};

   always #4 clk_sys = ~clk_sys;

   uspc_top uspc_top_inst (
      .clk_sys(clk_sys), .nrst(nrst),
      .usb_suspend_det(ev[4]), .usb_resume_det(ev[3]), .usb_resume_gen(ev[2]),
      .usb_bus_reset(ev[1]), .usb_config_done(ev[0]),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .std_clear_to_send_n(std_clear_to_send_n), .enh_clear_to_send_n(enh_clear_to_send_n),
      .std_ready_to_send_n(std_ready_to_send_n), .enh_ready_to_send_n(enh_ready_to_send_n),
      .std_rx_ready(std_rx_ready), .enh_rx_ready(enh_rx_ready),
      .std_tx_grant(std_tx_grant), .enh_tx_grant(enh_tx_grant),
      .std_modem_status(std_modem_status), .enh_modem_status(enh_modem_status),
      .enh_modem_mode(enh_modem_mode), .std_modem_mode(std_modem_mode),
      .side_pin_in(pad), .side_pin_out(pin_out), .side_pin_oe(pin_oe)
   );

   uspc_far_side uspc_far_side_inst (
      .pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_lvl(ext_lvl), .pad(pad)
   );

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected {oe, out} of all side pins in GPIO mode
   function automatic logic [31:0] pin_exp(input logic [7:0] v, d, od, input logic ind, pol);
      logic [7:0] oe;
      logic [7:0] out;
      oe  = ((d & ~(od & v)) & uspc_pkg::PIN_GPIO_MASK) | uspc_pkg::PIN_SUS_MASK;
      out = (v & ~od) | ({8{ind ~^ pol}} & uspc_pkg::PIN_SUS_MASK);
      return {16'h0000, oe, out};
   endfunction

   task automatic check(input string what, input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic report_and_stop;
      $display("Checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic do_reset;
      nrst <= 1'b0;
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
      notes.push_back('{2'd0, m, e});
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic observe(input logic [1:0] k, input logic [31:0] m, e);
      notes.push_back('{k, m, e});
      obs_req <= 1'b1;
      @(posedge clk_sys);
      obs_req <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic obs_pins(input logic [31:0] e);
      observe(2'd1, {16'h0000, 8'hFF, e[15:8]}, e);
   endtask

   task automatic pulse(input logic [4:0] v);
      ev <= v;
      @(posedge clk_sys);
      ev <= 5'h00;
      repeat (2) @(posedge clk_sys);
   endtask

   // Result watcher: oldest note against what the design shows
   always @(posedge clk_sys) begin
      uspc_note_t n;
      if (rd_d || obs_req) begin
         if (notes.size() == 0) begin
            fail_count++;
            $display("Error notes expected entry seen none");
         end else begin
            n = notes.pop_front();
            if (n.kind == 2'd0) check("reg_rdata", reg_rdata & n.mask, n.exp & n.mask);
            else if (n.kind == 2'd1) check("side_pins", {16'h0, pin_oe, pin_out} & n.mask,
                                           n.exp & n.mask);
            else check("flow_modem", misc & n.mask, n.exp & n.mask);
         end
      end
      rd_d <= reg_rd;
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      $display("Error watchdog expected done seen timeout");
      report_and_stop();
   end

   initial begin
      lfsr = 32'h2909;
      do_reset();
      obs_pins(pin_exp(8'h00, 8'h00, 8'h00, 1'b1, 1'b0));
      observe(2'd2, 32'h0000_0FFF, 32'h0000_0300);
      rd(uspc_pkg::OFS_STATUS, 32'h1F, 32'h04);
      rd(8'h10, 32'hFFFF_FFFF, 32'h0);
      pulse(5'b10000);
      rd(uspc_pkg::OFS_STATUS, 32'h1F, 32'h07);
      pulse(5'b01000);
      rd(uspc_pkg::OFS_STATUS, 32'h1F, 32'h04);
      wr(uspc_pkg::OFS_CONFIG, 32'h0002_1100);
      wr(uspc_pkg::OFS_CONFIG, 32'h0000_0007);
      rd(uspc_pkg::OFS_CONFIG, 32'hFFFF_FFFF, 32'h0002_1100);
      rd(uspc_pkg::OFS_STATUS, 32'h1F, 32'h0C);
      observe(2'd2, 32'h0000_00C0, 32'h0);
      lfsr = lfsr_next(lfsr);
      gv = lfsr[7:0];
      gd = lfsr[15:8] | 8'h01;
      wr(uspc_pkg::OFS_GPIO, {16'h0000, gd, gv});
      pulse(5'b00001);
      obs_pins(pin_exp(gv, gd, 8'h02, 1'b0, 1'b0));
      rd(uspc_pkg::OFS_STATUS, 32'h1F, 32'h19);
      // Each exit event in turn
      for (int i = 1; i < 4; i++) begin
         pulse(5'b10000);
         obs_pins(pin_exp(8'h11, gd, 8'h02, 1'b1, 1'b0));
         rd(uspc_pkg::OFS_STATUS, 32'h1F, 32'h1F);
         pulse(5'b10000 >> i);
         obs_pins(pin_exp(gv, gd, 8'h02, 1'b0, 1'b0));
      end
      enh_clear_to_send_n <= 1'b0;
      std_rx_ready <= 1'b1;
      wr(uspc_pkg::OFS_MODEM, 32'h0000_0008);
      repeat (3) @(posedge clk_sys);
      observe(2'd2, 32'h0000_0F00, 32'h0000_0400);
      // Second run with the enhanced port in modem mode
      enh_clear_to_send_n <= 1'b1;
      std_rx_ready <= 1'b0;
      ext_en  <= 8'h0E;
      ext_lvl <= 8'h04;
      do_reset();
      wr(uspc_pkg::OFS_CONFIG, 32'h0000_0006);
      repeat (3) @(posedge clk_sys);
      obs_pins({16'h0000, 8'h81, 8'h81});
      observe(2'd2, 32'h0000_0FFF, 32'h0000_0345);
      wr(uspc_pkg::OFS_MODEM, 32'h0000_0002);
      obs_pins({16'h0000, 8'h81, 8'h80});
      pulse(5'b00001);
      obs_pins({16'h0000, 8'h81, 8'h00});
      pulse(5'b10000);
      obs_pins({16'h0000, 8'h81, 8'h80});
      pulse(5'b00010);
      obs_pins({16'h0000, 8'h81, 8'h00});
      // Third run with the standard port in modem mode
      std_clear_to_send_n <= 1'b0;
      enh_rx_ready <= 1'b1;
      ext_en  <= 8'hD0;
      ext_lvl <= 8'h40;
      do_reset();
      wr(uspc_pkg::OFS_CONFIG, 32'h0000_0001);
      wr(uspc_pkg::OFS_MODEM, 32'h0000_0005);
      obs_pins({16'h0000, 8'h28, 8'h00});
      observe(2'd2, 32'h0000_0FFF, 32'h0000_08B0);
      rd(uspc_pkg::OFS_STATUS, 32'h00FF_FF1F, 32'h0046_470C);
      for (int i = 0; i < 10 && notes.size() > 0; i++) @(posedge clk_sys);
      if (notes.size() > 0) begin
         fail_count++;
         $display("Error notes expected empty seen %0d", notes.size());
      end
      report_and_stop();
   end
endmodule

// ==== verification/uspc_far_side.sv ====
`timescale 1ns/1ps
module uspc_far_side (
   // Design pad drive
   input  wire logic [uspc_pkg::NUM_PINS-1:0] pin_out,
   input  wire logic [uspc_pkg::NUM_PINS-1:0] pin_oe,
   // External drivers
   input  wire logic [uspc_pkg::NUM_PINS-1:0] ext_en,
   input  wire logic [uspc_pkg::NUM_PINS-1:0] ext_lvl,
   // Resolved pads
   output logic      [uspc_pkg::NUM_PINS-1:0] pad
);
   // Pull-up wins only when nobody drives
   always_comb begin
      for (int i = 0; i < uspc_pkg::NUM_PINS; i++) begin
         pad[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_lvl[i] : 1'b1);
      end
   end
endmodule
